// [core/awc_conv_seq.sv]
// conversion sequencer: paces one conversion over the sar clock periods and captures the code
`timescale 1ns/1ps
`include "awc_defs.svh"

module awc_conv_seq #(
    parameter int CONV_CLKS = `AWC_CONV_SAR_CLKS
) (
    input  wire logic       clk_sys,
    input  wire logic       rst_n,
    input  wire logic       conv_start,
    input  wire logic [4:0] sar_div,
    input  wire logic [9:0] sar_code,
    output logic            busy,
    output logic            done,
    output logic [9:0]      code
);
    awc_pkg::awc_seq_state_t state;
    logic [4:0] div_q;
    logic [4:0] div_cnt;
    logic [3:0] sar_cnt;
    logic       last_period;

    assign last_period = (div_cnt == div_q) && (sar_cnt == 4'(CONV_CLKS - 1));

    // a start during a conversion is ignored so a result never comes early
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            state <= awc_pkg::AWC_IDLE;
        end else begin
            unique case (state)
                awc_pkg::AWC_IDLE: begin
                    if (conv_start) begin
                        state <= awc_pkg::AWC_CONV;
                    end
                end
                awc_pkg::AWC_CONV: begin
                    if (last_period) begin
                        state <= awc_pkg::AWC_IDLE;
                    end
                end
            endcase
        end
    end

    // sar clock is sysclk / (div + 1); divider latched so a mid-conversion write cannot shorten it
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            div_q   <= `AWC_RESET_DIV;
            div_cnt <= 5'h00;
            sar_cnt <= 4'h0;
        end else if (state == awc_pkg::AWC_IDLE) begin
            div_q   <= sar_div;
            div_cnt <= 5'h00;
            sar_cnt <= 4'h0;
        end else if (div_cnt == div_q) begin
            div_cnt <= 5'h00;
            sar_cnt <= sar_cnt + 4'h1;
        end else begin
            div_cnt <= div_cnt + 5'h01;
        end
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            busy <= 1'b0;
            done <= 1'b0;
            code <= 10'h000;
        end else begin
            busy <= (state == awc_pkg::AWC_IDLE) ? conv_start : !last_period;
            done <= (state == awc_pkg::AWC_CONV) && last_period;
            if ((state == awc_pkg::AWC_CONV) && last_period) begin
                code <= sar_code;
            end
        end
    end

    // helper: sysclk cycles spent converting
    logic [8:0] conv_cycles;
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            conv_cycles <= 9'h000;
        end else if (state == awc_pkg::AWC_IDLE) begin
            conv_cycles <= 9'h000;
        end else begin
            conv_cycles <= conv_cycles + 9'h001;
        end
    end

    a_conv_min_time: assert property (@(posedge clk_sys) disable iff (!rst_n)
        done |-> conv_cycles == 9'(CONV_CLKS * (int'(div_q) + 1)))
        else $error("conversion ended before its sar clock periods");

endmodule : awc_conv_seq

// [core/awc_defs.svh]
// register offsets, field positions, reset values and timing counts of the window compare block
`ifndef AWC_DEFS_SVH
`define AWC_DEFS_SVH

`define AWC_OFS_RESULT_LOW      8'hBD
`define AWC_OFS_RESULT_HIGH     8'hBE
`define AWC_OFS_LOWER_LOW       8'hC3
`define AWC_OFS_LOWER_HIGH      8'hC4
`define AWC_OFS_UPPER_LOW       8'hC5
`define AWC_OFS_UPPER_HIGH      8'hC6
`define AWC_OFS_CONTROL         8'hE8

`define AWC_BIT_MATCH_FLAG      3
`define AWC_RESET_BYTE          8'h00
`define AWC_RESET_DIV           5'h1F

`define AWC_CONV_SAR_CLKS       10
`define AWC_CODE_BITS           10
`define AWC_LEFT_PAD            6
`define AWC_DIFF_MOST_NEG       10'h200
`define AWC_DIFF_MOST_POS       10'h1FF

`endif

// [core/awc_pkg.sv]
// types shared by the window compare block
package awc_pkg;

    typedef struct packed {
        logic [7:0] high;
        logic [7:0] low;
    } awc_word_t;

    typedef struct packed {
        logic justify_left;
        logic differential;
    } awc_fmt_t;

    typedef enum logic {
        AWC_IDLE = 1'b0,
        AWC_CONV = 1'b1
    } awc_seq_state_t;

endpackage : awc_pkg

// [core/awc_window_compare.sv]
// window detector: limit registers, result formatting and match flag of a 10-bit converter
// How it works
// - Upper-limit high byte is a read/write byte register that resets to zero.
// - Upper-limit low byte is a read/write byte register that resets to zero.
// - Single-ended results and limits are compared as unsigned numbers.
// - Inside mode matches only when lower < result < upper, never on equality.
// - Outside mode matches when the result lies beyond the window, above the lower limit or below the upper limit.
// - Right-justified differential results are 10-bit two's complement, sign-extended to 16 bits.
// - Differential compares are signed, so an all-ones limit is minus one.
// - Right-justified differential results run from 0xFE00 (most negative) to 0x01FF.
// - The flag is set by a match or by a control write of one to its bit; a miss leaves it as it was.
// - A conversion lasts at least ten sar clock periods before its result is compared.
// - Every new result is compared against the limits with no software help.
// - Inside or outside detection follows from the limit contents, with no mode bit.
// - Justify select zero gives right-justified words, one gives left-justified with zero low bits.
`timescale 1ns/1ps
`include "awc_defs.svh"

module awc_window_compare (
    input  wire logic       clk_sys,
    input  wire logic       rst_n,
    input  wire logic [7:0] sfr_addr,
    input  wire logic [7:0] sfr_wdata,
    input  wire logic       sfr_we,
    input  wire logic       sfr_re,
    input  wire logic       result_justify_select,
    input  wire logic       differential_select,
    input  wire logic [4:0] sar_div,
    input  wire logic       conv_start,
    input  wire logic [9:0] sar_code,
    output logic [7:0]      sfr_rdata,
    output logic [7:0]      result_high_byte,
    output logic [7:0]      result_low_byte,
    output logic            window_match_flag,
    output logic            conv_busy,
    output logic            conv_done
);
    awc_pkg::awc_word_t window_upper_limit;
    awc_pkg::awc_word_t window_lower_limit;
    awc_pkg::awc_word_t next_result;
    awc_pkg::awc_fmt_t  fmt;
    logic               seq_busy;
    logic               seq_done;
    logic [9:0]         seq_code;
    logic [15:0]        word;
    logic [15:0]        ul;
    logic [15:0]        ll;
    logic               above_lower;
    logic               below_upper;
    logic               inside_mode;
    logic               match;
    logic               ctrl_write;

    awc_conv_seq #(
        .CONV_CLKS (`AWC_CONV_SAR_CLKS)
    ) u_seq (
        .clk_sys    (clk_sys),
        .rst_n      (rst_n),
        .conv_start (conv_start),
        .sar_div    (sar_div),
        .sar_code   (sar_code),
        .busy       (seq_busy),
        .done       (seq_done),
        .code       (seq_code)
    );

    assign fmt  = '{justify_left: result_justify_select, differential: differential_select};
    assign ul   = window_upper_limit;
    assign ll   = window_lower_limit;
    assign ctrl_write = sfr_we && (sfr_addr == `AWC_OFS_CONTROL);

    // left-justified words carry the sign in bit 15 already, so only right-justified ones extend it
    always_comb begin
        if (fmt.justify_left) begin
            word = {seq_code, `AWC_LEFT_PAD'h00};
        end else if (fmt.differential) begin
            word = {{`AWC_LEFT_PAD{seq_code[9]}}, seq_code};
        end else begin
            word = {`AWC_LEFT_PAD'h00, seq_code};
        end
        next_result = word;
    end

    // whole 16-bit images are compared, hence limits must share the result justification
    always_comb begin
        if (fmt.differential) begin
            above_lower = $signed(word) > $signed(ll);
            below_upper = $signed(word) < $signed(ul);
            inside_mode = $signed(ul) > $signed(ll);
        end else begin
            above_lower = word > ll;
            below_upper = word < ul;
            inside_mode = ul > ll;
        end
        if (inside_mode) begin
            match = above_lower && below_upper;
        end else begin
            // swapped limits: the window edges are the upper limit (low edge) and the lower limit (high edge)
            match = above_lower || below_upper;
        end
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            window_upper_limit <= {`AWC_RESET_BYTE, `AWC_RESET_BYTE};
            window_lower_limit <= {`AWC_RESET_BYTE, `AWC_RESET_BYTE};
        end else if (sfr_we) begin
            unique case (sfr_addr)
                `AWC_OFS_UPPER_HIGH: window_upper_limit.high <= sfr_wdata;
                `AWC_OFS_UPPER_LOW:  window_upper_limit.low  <= sfr_wdata;
                `AWC_OFS_LOWER_HIGH: window_lower_limit.high <= sfr_wdata;
                `AWC_OFS_LOWER_LOW:  window_lower_limit.low  <= sfr_wdata;
                default: begin
                end
            endcase
        end
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            result_high_byte <= `AWC_RESET_BYTE;
            result_low_byte  <= `AWC_RESET_BYTE;
        end else if (seq_done) begin
            result_high_byte <= next_result.high;
            result_low_byte  <= next_result.low;
        end
    end

    // a match in the same cycle as a software clear wins
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            window_match_flag <= 1'b0;
        end else if (seq_done && match) begin
            window_match_flag <= 1'b1;
        end else if (ctrl_write) begin
            window_match_flag <= sfr_wdata[`AWC_BIT_MATCH_FLAG];
        end
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            sfr_rdata <= 8'h00;
        end else if (sfr_re) begin
            unique case (sfr_addr)
                `AWC_OFS_UPPER_HIGH:  sfr_rdata <= window_upper_limit.high;
                `AWC_OFS_UPPER_LOW:   sfr_rdata <= window_upper_limit.low;
                `AWC_OFS_LOWER_HIGH:  sfr_rdata <= window_lower_limit.high;
                `AWC_OFS_LOWER_LOW:   sfr_rdata <= window_lower_limit.low;
                `AWC_OFS_RESULT_HIGH: sfr_rdata <= result_high_byte;
                `AWC_OFS_RESULT_LOW:  sfr_rdata <= result_low_byte;
                `AWC_OFS_CONTROL:     sfr_rdata <= 8'(window_match_flag) << `AWC_BIT_MATCH_FLAG;
                default:              sfr_rdata <= 8'h00;
            endcase
        end
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            conv_busy <= 1'b0;
            conv_done <= 1'b0;
        end else begin
            conv_busy <= seq_busy;
            conv_done <= seq_done;
        end
    end

    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rst_n);

    sequence s_new_result;
        seq_done ##1 1'b1;
    endsequence

    sequence s_result_loaded;
        {result_high_byte, result_low_byte} == $past(next_result) && conv_done;
    endsequence

    a_upper_high_wr: assert property (sfr_we && sfr_addr == `AWC_OFS_UPPER_HIGH
        |=> window_upper_limit.high == $past(sfr_wdata))
        else $error("upper limit high byte did not take the write");

    a_upper_high_rd: assert property (sfr_re && sfr_addr == `AWC_OFS_UPPER_HIGH
        |=> sfr_rdata == $past(window_upper_limit.high))
        else $error("upper limit high byte read back wrong");

    a_upper_low_wr: assert property (sfr_we && sfr_addr == `AWC_OFS_UPPER_LOW
        |=> window_upper_limit.low == $past(sfr_wdata))
        else $error("upper limit low byte did not take the write");

    a_inside_match: assert property (seq_done && !fmt.differential && ul > ll
        && word > ll && word < ul |=> window_match_flag)
        else $error("unsigned inside result did not set the flag");

    a_inside_equal: assert property (seq_done && !fmt.differential && ul > ll && word == ul
        && !window_match_flag && !ctrl_write |=> !window_match_flag)
        else $error("result equal to upper limit set the flag");

    a_outside_match: assert property (seq_done && !(ul > ll) && !fmt.differential
        && (word > ll || word < ul) |=> window_match_flag)
        else $error("outside result did not set the flag");

    a_diff_sign_ext: assert property (seq_done && fmt.differential && !fmt.justify_left
        |=> result_high_byte[7:2] == {6{result_high_byte[1]}})
        else $error("differential result not sign-extended");

    a_diff_minus_one: assert property (seq_done && fmt.differential && ll == 16'hFFFF
        && ul == 16'h0040 && word == 16'h0000 |=> window_match_flag)
        else $error("all-ones lower limit not treated as minus one");

    a_diff_most_neg: assert property (seq_done && fmt.differential && !fmt.justify_left
        && seq_code == `AWC_DIFF_MOST_NEG |=> {result_high_byte, result_low_byte} == 16'hFE00)
        else $error("most negative differential code misformatted");

    a_miss_holds: assert property (seq_done && !match && !ctrl_write
        |=> window_match_flag == $past(window_match_flag))
        else $error("a non-matching result changed the flag");

    a_every_result: assert property (s_new_result |-> s_result_loaded)
        else $error("new result not loaded and announced");

    a_equal_limits: assert property (seq_done && ul == ll && word != ll
        |=> window_match_flag)
        else $error("equal limits did not give outside detection");

    a_left_zero_low: assert property (seq_done && fmt.justify_left
        |=> result_low_byte[5:0] == 6'h00 ##1 result_low_byte[5:0] == 6'h00 || $past(seq_done))
        else $error("left-justified low bits not zero");

endmodule : awc_window_compare

// [sim/awc_window_compare_bench.sv]
// self-checking bench for the window compare block
`timescale 1ns/1ps
`include "awc_defs.svh"

module awc_window_compare_bench;
    typedef struct packed {
        logic        diff;
        logic        just;
        logic [15:0] lower;
        logic [15:0] upper;
        logic [9:0]  code;
        logic        flag;
    } awc_row_t;

    logic       clk_sys = 1'b0;
    logic       rst_n = 1'b0;
    logic [7:0] sfr_addr = 8'h00;
    logic [7:0] sfr_wdata = 8'h00;
    logic       sfr_we = 1'b0;
    logic       sfr_re = 1'b0;
    logic       result_justify_select = 1'b0;
    logic       differential_select = 1'b0;
    logic [4:0] sar_div = 5'h00;
    logic       conv_start = 1'b0;
    logic [9:0] sar_code = 10'h000;
    logic [7:0] sfr_rdata;
    logic [7:0] result_high_byte;
    logic [7:0] result_low_byte;
    logic       window_match_flag;
    logic       conv_busy;
    logic       conv_done;
    int         err_count = 0;
    int         total_checks = 0;
    int         cycles = 0;
    int         cyc;
    logic [7:0] rd_val;
    awc_row_t   rows[17] = '{
        '{1'b0, 1'b0, 16'h0040, 16'h0080, 10'h041, 1'b1}, '{1'b0, 1'b0, 16'h0040, 16'h0080, 10'h040, 1'b0},
        '{1'b0, 1'b0, 16'h0040, 16'h0080, 10'h080, 1'b0}, '{1'b0, 1'b0, 16'h0080, 16'h0040, 10'h03F, 1'b1},
        '{1'b0, 1'b0, 16'h0080, 16'h0040, 10'h040, 1'b0}, '{1'b0, 1'b0, 16'h0080, 16'h0040, 10'h081, 1'b1},
        '{1'b0, 1'b1, 16'h1000, 16'hFFFF, 10'h3FF, 1'b1}, '{1'b1, 1'b0, 16'hFFFF, 16'h0040, 10'h000, 1'b1},
        '{1'b1, 1'b0, 16'hFFFF, 16'h0040, 10'h3FF, 1'b0}, '{1'b1, 1'b0, 16'hFFFF, 16'h0040, 10'h200, 1'b0},
        '{1'b1, 1'b0, 16'h0040, 16'hFFFF, 10'h3FE, 1'b1}, '{1'b1, 1'b0, 16'h0040, 16'hFFFF, 10'h1FF, 1'b1},
        '{1'b1, 1'b0, 16'h0040, 16'hFFFF, 10'h3FF, 1'b0}, '{1'b0, 1'b1, 16'h1000, 16'h2000, 10'h041, 1'b1},
        '{1'b0, 1'b1, 16'h1000, 16'h2000, 10'h080, 1'b0}, '{1'b1, 1'b1, 16'hFFC0, 16'h1000, 10'h000, 1'b1},
        '{1'b1, 1'b1, 16'hFFC0, 16'h1000, 10'h200, 1'b0}};

    awc_window_compare i_dut (
        .clk_sys               (clk_sys),
        .rst_n                 (rst_n),
        .sfr_addr              (sfr_addr),
        .sfr_wdata             (sfr_wdata),
        .sfr_we                (sfr_we),
        .sfr_re                (sfr_re),
        .result_justify_select (result_justify_select),
        .differential_select   (differential_select),
        .sar_div               (sar_div),
        .conv_start            (conv_start),
        .sar_code              (sar_code),
        .sfr_rdata             (sfr_rdata),
        .result_high_byte      (result_high_byte),
        .result_low_byte       (result_low_byte),
        .window_match_flag     (window_match_flag),
        .conv_busy             (conv_busy),
        .conv_done             (conv_done)
    );

    always #12.5 clk_sys = ~clk_sys;

    task automatic give_verdict;
        $display("checks %0d mismatches %0d", total_checks, err_count);
        if (err_count == 0 && total_checks > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask : give_verdict

    // a hang is cut off well beyond the few hundred cycles the run needs
    always @(posedge clk_sys) begin
        cycles++;
        if (cycles == 20000) begin
            err_count++;
            give_verdict();
        end
    end

    task automatic chk(input logic [15:0] seen, input logic [15:0] exp, input string msg);
        total_checks++;
        if (seen !== exp) begin
            err_count++;
            $display("CHECK FAILED at %0t: %s seen %h expected %h", $time, msg, seen, exp);
        end
    endtask : chk

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk_sys);
        sfr_addr <= a;
        sfr_wdata <= d;
        sfr_we <= 1'b1;
        @(posedge clk_sys);
        sfr_we <= 1'b0;
    endtask : wr

    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge clk_sys);
        sfr_addr <= a;
        sfr_re <= 1'b1;
        @(posedge clk_sys);
        sfr_re <= 1'b0;
        @(posedge clk_sys);
        #1;
        d = sfr_rdata;
    endtask : rd

    // sar_code is held for the whole conversion; extra fires a refused start mid-conversion
    task automatic conv(input logic [9:0] c, input logic extra);
        @(posedge clk_sys);
        sar_code <= c;
        conv_start <= 1'b1;
        @(posedge clk_sys);
        conv_start <= 1'b0;
        cyc = 0;
        while (cyc < 200) begin
            @(posedge clk_sys);
            conv_start <= extra && (cyc == 2);
            #1;
            cyc++;
            if (cyc == 1) chk(16'(conv_busy), 16'h0001, "busy while converting");
            if (conv_done === 1'b1) break;
        end
    endtask : conv

    function automatic logic [15:0] exp_word(input logic diff, input logic just, input logic [9:0] c);
        if (just) return {c, 6'b000000};
        return {{6{diff & c[9]}}, c};
    endfunction : exp_word

    initial begin
        repeat (3) @(posedge clk_sys);
        rst_n <= 1'b1;
        rd(`AWC_OFS_UPPER_HIGH, rd_val);
        chk(16'(rd_val), 16'h0000, "upper high reset");
        rd(`AWC_OFS_UPPER_LOW, rd_val);
        chk(16'(rd_val), 16'h0000, "upper low reset");
        wr(`AWC_OFS_UPPER_HIGH, 8'hA5);
        wr(`AWC_OFS_UPPER_LOW, 8'h5A);
        rd(`AWC_OFS_UPPER_HIGH, rd_val);
        chk(16'(rd_val), 16'h00A5, "upper high rw");
        rd(`AWC_OFS_UPPER_LOW, rd_val);
        chk(16'(rd_val), 16'h005A, "upper low rw");
        rd(8'h00, rd_val);
        chk(16'(rd_val), 16'h0000, "unmapped read");
        foreach (rows[i]) begin
            wr(`AWC_OFS_CONTROL, 8'h00);
            // limits are written in the same justification as the row's results
            wr(`AWC_OFS_LOWER_LOW, rows[i].lower[7:0]);
            wr(`AWC_OFS_LOWER_HIGH, rows[i].lower[15:8]);
            wr(`AWC_OFS_UPPER_LOW, rows[i].upper[7:0]);
            wr(`AWC_OFS_UPPER_HIGH, rows[i].upper[15:8]);
            @(posedge clk_sys);
            differential_select <= rows[i].diff;
            result_justify_select <= rows[i].just;
            conv(rows[i].code, 1'b0);
            chk(16'(cyc), 16'h000B, "done latency");
            chk(16'(conv_busy), 16'h0000, "busy after done");
            chk({result_high_byte, result_low_byte},
                exp_word(rows[i].diff, rows[i].just, rows[i].code), "result word");
            chk(16'(window_match_flag), 16'(rows[i].flag), "match flag");
        end
        // sticky flag: a miss after a match leaves it set
        wr(`AWC_OFS_LOWER_LOW, 8'h40);
        wr(`AWC_OFS_LOWER_HIGH, 8'h00);
        wr(`AWC_OFS_UPPER_LOW, 8'h80);
        wr(`AWC_OFS_UPPER_HIGH, 8'h00);
        @(posedge clk_sys);
        differential_select <= 1'b0;
        result_justify_select <= 1'b0;
        conv(10'h050, 1'b0);
        conv(10'h040, 1'b0);
        chk(16'(window_match_flag), 16'h0001, "flag kept after miss");
        rd(`AWC_OFS_CONTROL, rd_val);
        chk(16'(rd_val), 16'h0008, "control read");
        wr(`AWC_OFS_CONTROL, 8'h00);
        rd(`AWC_OFS_CONTROL, rd_val);
        chk(16'(rd_val), 16'h0000, "flag cleared");
        wr(`AWC_OFS_RESULT_HIGH, 8'hFF);
        rd(`AWC_OFS_RESULT_HIGH, rd_val);
        chk(16'(rd_val), 16'h0000, "result high read only");
        rd(`AWC_OFS_RESULT_LOW, rd_val);
        chk(16'(rd_val), 16'h0040, "result low read");
        // slower sar clock with a refused second start
        @(posedge clk_sys);
        sar_div <= 5'h01;
        conv(10'h07F, 1'b1);
        chk(16'(cyc), 16'h0015, "done latency div 1");
        chk(16'(window_match_flag), 16'h0001, "match at slow sar");
        @(posedge clk_sys);
        rst_n <= 1'b0;
        repeat (2) @(posedge clk_sys);
        rst_n <= 1'b1;
        chk(16'(window_match_flag), 16'h0000, "flag after reset");
        chk({result_high_byte, result_low_byte}, 16'h0000, "result after reset");
        rd(`AWC_OFS_UPPER_LOW, rd_val);
        chk(16'(rd_val), 16'h0000, "upper low after reset");
        give_verdict();
    end
endmodule : awc_window_compare_bench
